// ### verilog/rca_core.sv
// Two-stage fetch and execute core with its special registers
`timescale 1ns/100ps
`include "rca_cfg.svh"
module rca_core import rca_pkg::*; (
    input  wire logic             clk,
    input  wire logic             reset,
    output logic [`PC_W-1:0]      pm_addr,
    input  wire logic [`IW-1:0]   pm_rdata,
    output rca_dm_s               dm_req,
    input  wire logic [7:0]       dm_rdata,
    output rca_aux_s              aux,
    output logic                  cycle_tick
);
    localparam logic [2:0] CYC_LAST = 3'(`CLKS_PER_CYC - 1);

    logic [2:0]        phase_ff;
    logic              tick;
    logic [`IW-1:0]    ir_ff;
    logic [`PC_W-1:0]  pc_ff;
    logic [`PC_W-1:0]  nxt_pc;
    logic [`PC_W-1:0]  stack_ff [`STK_DEPTH];
    logic              sp_ff;
    logic [7:0]        w_ff;
    logic [7:0]        status_ff;
    logic [7:0]        nxt_status;
    logic [7:0]        fsr_ff;
    logic [2:0]        bsr_ff;
    rca_dec_s          dec;
    logic [4:0]        f;
    logic [7:0]        ea;
    logic              internal;
    logic [7:0]        fval;
    logic [7:0]        x;
    logic [7:0]        res;
    logic              c_out;
    logic              nib_out;
    logic              z;
    logic              flush;
    logic              push;
    logic              pop;
    logic              wr_ext;

    // =================================================================
    // Instruction cycle divider
    assign tick       = phase_ff == CYC_LAST;
    assign cycle_tick = tick;

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
        end
    end

    // =================================================================
    // Decode and operand fetch
    rca_decode u_dec (
        .ir  (ir_ff),
        .dec (dec)
    );

    assign f = ir_ff[4:0];
    // Address zero reads through the pointer register
    assign ea = (f == `A_IND) ? fsr_ff : {bsr_ff, f};
    assign internal = ea[4:0] == `A_IND || ea[4:0] == `A_PCL ||
                      ea[4:0] == `A_STATUS || ea[4:0] == `A_FSR;

    always_comb begin
        case (ea[4:0])
            `A_IND:    fval = 8'h00;
            `A_PCL:    fval = pc_ff[7:0];
            `A_STATUS: fval = status_ff;
            `A_FSR:    fval = fsr_ff;
            default:   fval = dm_rdata;
        endcase
    end

    assign x = dec.src_lit ? ir_ff[7:0] : fval;

    rca_alu u_alu (
        .op      (dec.alu),
        .x       (x),
        .w       (w_ff),
        .cin     (status_ff[`ST_C]),
        .bsel    (ir_ff[7:5]),
        .res     (res),
        .c_out   (c_out),
        .nib_out (nib_out)
    );

    assign z = res == 8'h00;

    // =================================================================
    // Program flow
    always_comb begin
        nxt_pc = pc_ff + 1'b1;
        flush  = 1'b0;
        push   = 1'b0;
        pop    = 1'b0;
        case (dec.flow)
            fl_skipz: flush = z;
            fl_bclr:  flush = !x[ir_ff[7:5]];
            fl_bset:  flush = x[ir_ff[7:5]];
            fl_goto: begin
                nxt_pc = ir_ff[`PC_W-1:0];
                flush  = 1'b1;
            end
            fl_call: begin
                nxt_pc = {1'b0, ir_ff[7:0]};
                push   = 1'b1;
                flush  = 1'b1;
            end
            fl_ret, fl_retfie: begin
                nxt_pc = stack_ff[sp_ff - 1'b1];
                pop    = 1'b1;
                flush  = 1'b1;
            end
            default: ;
        endcase
        // Writing the low program counter byte is a jump
        if (dec.dest_f && ea[4:0] == `A_PCL) begin
            nxt_pc = {1'b0, res};
            flush  = 1'b1;
        end
    end

    // The fetched word is replaced by a no-op so a branch costs a cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_ff <= `RST_PC;
            ir_ff <= `NOP_WORD;
        end else if (tick) begin
            pc_ff <= nxt_pc;
            ir_ff <= flush ? `NOP_WORD : pm_rdata;
        end
    end

    assign pm_addr = pc_ff;

    // Overflow silently wraps and overwrites the oldest return address
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_ff <= 1'b0;
        end else if (tick && push) begin
            stack_ff[sp_ff] <= pc_ff;
            sp_ff           <= sp_ff + 1'b1;
        end else if (tick && pop) begin
            sp_ff <= sp_ff - 1'b1;
        end
    end

    // =================================================================
    // Accumulator, only reached implicitly
    always_ff @(posedge clk) begin
        if (reset) begin
            w_ff <= 8'h00;
        end else if (tick && dec.wr_w) begin
            w_ff <= res;
        end
    end

    // =================================================================
    // Status, pointer and bank registers
    always_comb begin
        nxt_status = status_ff;
        if (dec.dest_f && ea[4:0] == `A_STATUS) begin
            nxt_status = res;
        end
        // Flag updates win over a direct write to status
        if (dec.upd_z) begin
            nxt_status[`ST_Z] = z;
        end
        if (dec.upd_cn) begin
            nxt_status[`ST_C] = c_out;
            nxt_status[`ST_N] = nib_out;
        end
        if (dec.upd_c) begin
            nxt_status[`ST_C] = c_out;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_ff <= `RST_STATUS;
        end else if (tick) begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fsr_ff <= 8'h00;
            bsr_ff <= 3'h0;
        end else if (tick) begin
            if (dec.dest_f && ea[4:0] == `A_FSR) begin
                fsr_ff <= res;
            end
            if (dec.set_bank) begin
                bsr_ff <= ir_ff[2:0];
            end
        end
    end

    // =================================================================
    // Data bus, separate from the program bus
    assign wr_ext = tick && dec.dest_f && !internal;

    always_ff @(posedge clk) begin
        if (reset) begin
            dm_req <= '0;
        end else begin
            dm_req.addr <= ea;
            dm_req.we   <= wr_ext;
            if (wr_ext) begin
                dm_req.wdata <= res;
            end
        end
    end

    // =================================================================
    // System commands handed to the surrounding chip
    always_ff @(posedge clk) begin
        if (reset) begin
            aux <= '{kind: aux_none, default: '0};
        end else begin
            aux.valid <= tick && dec.aux != aux_none;
            if (tick && dec.aux != aux_none) begin
                aux.kind <= dec.aux;
                aux.port <= ir_ff[2:0];
                aux.data <= w_ff;
            end
        end
    end

    // =================================================================
    // Checks
    logic [3:0] x_lo;
    logic [3:0] w_lo;
    logic       wr_f;
    assign x_lo = x[3:0];
    assign w_lo = w_ff[3:0];
    assign wr_f = tick && dec.dest_f;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence cyc_gap_s;
        !tick [*7] ##1 tick;
    endsequence

    sequence nop_slot_s;
        ir_ff == `NOP_WORD ##1 !tick [*6];
    endsequence

    cyc_len_a: assert property (tick |=> cyc_gap_s)
        else $error("instruction cycle length wrong");
    br_flush_a: assert property (tick && flush |=> nop_slot_s)
        else $error("branch did not insert a no-op cycle");
    fetch_word_a: assert property (tick && !flush |=> ir_ff == $past(pm_rdata))
        else $error("fetched word not loaded");
    pc_step_a: assert property (tick && !flush |=> pm_addr == $past(pm_addr) + 9'h001)
        else $error("program counter did not advance");
    zero_flag_a: assert property (tick && dec.upd_z |=> status_ff[`ST_Z] == $past(z))
        else $error("zero flag wrong");
    sub_borrow_a: assert property (tick && dec.alu == alu_sub && dec.upd_cn
        |=> status_ff[`ST_C] == ($past(x) >= $past(w_ff)))
        else $error("subtract carry is not inverted borrow");
    nib_carry_a: assert property (tick && dec.alu == alu_add && dec.upd_cn
        |=> status_ff[`ST_N] == (({1'b0, $past(x_lo)} + {1'b0, $past(w_lo)}) > 5'h0f))
        else $error("nibble carry wrong");
    acc_hidden_a: assert property (dm_req.we |-> $past(wr_f))
        else $error("data write without file destination");
    bus_split_a: assert property (wr_ext |=> dm_req.we && pm_addr != $past(pm_addr))
        else $error("data write and fetch not in the same cycle");

endmodule // rca_core

// ### inc/rca_cfg.svh
// Constants for the 8-bit core execution datapath
// Function
// - Exactly 36 single-word instructions
// - Single cycle; flow changes take two
// - Opcodes are 12 bits wide
// - One 12-bit word fetched per cycle
// - Fetch next while executing current
// - Cycle is 200 ns at 40 MHz
// - Separate program and data buses
// - Special registers, program counter, in data space
// - Direct and indirect addressing, any register
// - 8-bit add, subtract, shift, logic unit
// - Arithmetic is two's complement
// - Accumulator with file or literal operand
// - Single operand: accumulator or file
// - Accumulator has no data address
// - Update carry, nibble carry, zero flags
// - Subtract: carries are inverted borrows
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH

// =====================================================================
// Widths
`define IW          12
`define PC_W        9
`define STK_DEPTH   2

// =====================================================================
// Timing
`define CLK_T_NS    25
`define CYC_T_NS    200
`define CLKS_PER_CYC ((`CYC_T_NS + `CLK_T_NS - 1) / `CLK_T_NS)

// =====================================================================
// Data space map (low five address bits, mirrored in every bank)
`define A_IND       5'h00
`define A_PCL       5'h02
`define A_STATUS    5'h03
`define A_FSR       5'h04

// =====================================================================
// Status bit positions and reset values
`define ST_C        0
`define ST_N        1
`define ST_Z        2
`define RST_STATUS  8'h00
`define RST_PC      9'h000
`define NOP_WORD    12'h000

`endif

// ### inc/rca_pkg.sv
// Types shared by the core datapath modules
`include "rca_cfg.svh"
package rca_pkg;

    typedef enum logic [3:0] {
        alu_pass_x, alu_pass_w, alu_add, alu_sub, alu_and, alu_or, alu_xor,
        alu_com, alu_inc, alu_dec, alu_rr, alu_rl, alu_swap, alu_clr,
        alu_bclr, alu_bset
    } rca_alu_e;

    typedef enum logic [2:0] {
        fl_none, fl_skipz, fl_bclr, fl_bset, fl_goto, fl_call, fl_ret, fl_retfie
    } rca_flow_e;

    typedef enum logic [2:0] {
        aux_none, aux_option, aux_sleep, aux_wdt, aux_tris, aux_retfie
    } rca_aux_e;

    typedef struct packed {
        rca_alu_e  alu;
        logic      src_lit;
        logic      dest_f;
        logic      wr_w;
        logic      upd_z;
        logic      upd_cn;
        logic      upd_c;
        logic      set_bank;
        rca_flow_e flow;
        rca_aux_e  aux;
    } rca_dec_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
    } rca_dm_s;

    typedef struct packed {
        logic       valid;
        rca_aux_e   kind;
        logic [2:0] port;
        logic [7:0] data;
    } rca_aux_s;

endpackage

// ### verilog/rca_alu.sv
// Eight-bit arithmetic and logic unit
`timescale 1ns/100ps
`include "rca_cfg.svh"
module rca_alu import rca_pkg::*; (
    input  wire rca_alu_e   op,
    input  wire logic [7:0] x,
    input  wire logic [7:0] w,
    input  wire logic       cin,
    input  wire logic [2:0] bsel,
    output logic [7:0]      res,
    output logic            c_out,
    output logic            nib_out
);
    logic [4:0] lo;
    logic [8:0] full;

    // =================================================================
    // Operation select
    always_comb begin
        lo      = {1'b0, x[3:0]} + {1'b0, w[3:0]};
        full    = {1'b0, x} + {1'b0, w};
        res     = x;
        c_out   = cin;
        nib_out = 1'b0;
        case (op)
            alu_pass_w: res = w;
            alu_add: begin
                res     = full[7:0];
                c_out   = full[8];
                nib_out = lo[4];
            end
            alu_sub: begin
                // Add the complement plus one, so carries are not-borrows
                lo      = {1'b0, x[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                full    = {1'b0, x} + {1'b0, ~w} + 9'h001;
                res     = full[7:0];
                c_out   = full[8];
                nib_out = lo[4];
            end
            alu_and:  res = x & w;
            alu_or:   res = x | w;
            alu_xor:  res = x ^ w;
            alu_com:  res = ~x;
            alu_inc:  res = x + 8'h01;
            alu_dec:  res = x - 8'h01;
            alu_rr: begin
                res   = {cin, x[7:1]};
                c_out = x[0];
            end
            alu_rl: begin
                res   = {x[6:0], cin};
                c_out = x[7];
            end
            alu_swap: res = {x[3:0], x[7:4]};
            alu_clr:  res = 8'h00;
            alu_bclr: res = x & ~(8'h01 << bsel);
            alu_bset: res = x | (8'h01 << bsel);
            default:  res = x;
        endcase
    end

endmodule // rca_alu

// ### verilog/rca_decode.sv
// Instruction decoder for the 12-bit instruction word
`timescale 1ns/100ps
`include "rca_cfg.svh"
module rca_decode import rca_pkg::*; (
    input  wire logic [`IW-1:0] ir,
    output rca_dec_s            dec
);
    // =================================================================
    // Decode of the 36 instructions; unused patterns act as no-ops
    always_comb begin
        dec = '{alu: alu_pass_x, flow: fl_none, aux: aux_none, default: 1'b0};
        casez (ir)
            12'b0000_0000_0000: ;
            12'b0000_0000_0010: dec.aux = aux_option;
            12'b0000_0000_0011: dec.aux = aux_sleep;
            12'b0000_0000_0100: dec.aux = aux_wdt;
            12'b0000_0000_01??: dec.aux = aux_tris;
            12'b0000_0001_1110: dec.flow = fl_ret;
            12'b0000_0001_1111: begin
                dec.flow = fl_retfie;
                dec.aux  = aux_retfie;
            end
            12'b0000_0001_0???: dec.set_bank = 1'b1;
            12'b0000_001?_????: begin
                dec.alu    = alu_pass_w;
                dec.dest_f = 1'b1;
            end
            12'b0000_0100_0000: begin
                dec.alu   = alu_clr;
                dec.wr_w  = 1'b1;
                dec.upd_z = 1'b1;
            end
            12'b0000_011?_????: begin
                dec.alu    = alu_clr;
                dec.dest_f = 1'b1;
                dec.upd_z  = 1'b1;
            end
            12'b00??_????_????: begin
                dec.dest_f = ir[5];
                dec.wr_w   = !ir[5];
                dec.upd_z  = 1'b1;
                case (ir[9:6])
                    4'h2: begin
                        dec.alu    = alu_sub;
                        dec.upd_cn = 1'b1;
                    end
                    4'h3: dec.alu = alu_dec;
                    4'h4: dec.alu = alu_or;
                    4'h5: dec.alu = alu_and;
                    4'h6: dec.alu = alu_xor;
                    4'h7: begin
                        dec.alu    = alu_add;
                        dec.upd_cn = 1'b1;
                    end
                    4'h8: dec.alu = alu_pass_x;
                    4'h9: dec.alu = alu_com;
                    4'ha: dec.alu = alu_inc;
                    4'hb: begin
                        dec.alu   = alu_dec;
                        dec.upd_z = 1'b0;
                        dec.flow  = fl_skipz;
                    end
                    4'hc: begin
                        dec.alu   = alu_rr;
                        dec.upd_z = 1'b0;
                        dec.upd_c = 1'b1;
                    end
                    4'hd: begin
                        dec.alu   = alu_rl;
                        dec.upd_z = 1'b0;
                        dec.upd_c = 1'b1;
                    end
                    4'he: begin
                        dec.alu   = alu_swap;
                        dec.upd_z = 1'b0;
                    end
                    4'hf: begin
                        dec.alu   = alu_inc;
                        dec.upd_z = 1'b0;
                        dec.flow  = fl_skipz;
                    end
                    default: begin
                        dec.dest_f = 1'b0;
                        dec.wr_w   = 1'b0;
                        dec.upd_z  = 1'b0;
                    end
                endcase
            end
            12'b0100_????_????: begin
                dec.alu    = alu_bclr;
                dec.dest_f = 1'b1;
            end
            12'b0101_????_????: begin
                dec.alu    = alu_bset;
                dec.dest_f = 1'b1;
            end
            12'b0110_????_????: dec.flow = fl_bclr;
            12'b0111_????_????: dec.flow = fl_bset;
            12'b1000_????_????: begin
                dec.src_lit = 1'b1;
                dec.wr_w    = 1'b1;
                dec.flow    = fl_ret;
            end
            12'b1001_????_????: dec.flow = fl_call;
            12'b101?_????_????: dec.flow = fl_goto;
            12'b11??_????_????: begin
                dec.src_lit = 1'b1;
                dec.wr_w    = 1'b1;
                dec.upd_z   = ir[9:8] != 2'b00;
                case (ir[9:8])
                    2'b01:   dec.alu = alu_or;
                    2'b10:   dec.alu = alu_and;
                    2'b11:   dec.alu = alu_xor;
                    default: dec.alu = alu_pass_x;
                endcase
            end
            default: ;
        endcase
    end

endmodule // rca_decode

// ### bench/rca_mem_model.sv
// Program memory and data register file model facing the core
`timescale 1ns/100ps
`include "rca_cfg.svh"
module rca_mem_model import rca_pkg::*; (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [`PC_W-1:0] pm_addr,
    output logic [`IW-1:0]        pm_rdata,
    input  wire rca_dm_s          dm_req,
    output logic [7:0]            dm_rdata,
    input  wire logic             cycle_tick
);
    logic [`IW-1:0] rom [0:(1<<`PC_W)-1];
    logic [7:0]     ram [0:255];
    logic [7:0]     log_addr [$];
    logic [7:0]     log_data [$];
    int             log_tick [$];
    int             tick_n;

    // =========================================================
    // Read paths
    // Separate program bus: one whole word per fetch
    assign pm_rdata = rom[pm_addr];
    assign dm_rdata = ram[dm_req.addr];

    initial begin
        foreach (rom[i]) rom[i] = `NOP_WORD;
        foreach (ram[i]) ram[i] = 8'h00;
        tick_n = 0;
    end

    // =========================================================
    // Write capture, tagged with the instruction cycle it landed in
    always @(posedge clk) begin
        if (reset) begin
            tick_n = 0;
            log_addr.delete();
            log_data.delete();
            log_tick.delete();
        end else begin
            if (cycle_tick) tick_n++;
            if (dm_req.we) begin
                ram[dm_req.addr] = dm_req.wdata;
                log_addr.push_back(dm_req.addr);
                log_data.push_back(dm_req.wdata);
                log_tick.push_back(tick_n);
            end
        end
    end
endmodule // rca_mem_model

// ### bench/testbench.sv
// Self-checking bench for the two-stage core datapath
`timescale 1ns/100ps
`include "rca_cfg.svh"
module testbench;
    import rca_pkg::*;

    logic             clk;
    logic             reset;
    logic [`PC_W-1:0] pm_addr;
    logic [`IW-1:0]   pm_rdata;
    rca_dm_s          dm_req;
    logic [7:0]       dm_rdata;
    logic             cycle_tick;
    rca_aux_s         aux_w;
    rca_aux_s         aux_last;
    int               aux_n;
    int               n_mismatch;
    int               cmp_count;

    rca_core dut_u (
        .clk        (clk),
        .reset      (reset),
        .pm_addr    (pm_addr),
        .pm_rdata   (pm_rdata),
        .dm_req     (dm_req),
        .dm_rdata   (dm_rdata),
        .aux        (aux_w),
        .cycle_tick (cycle_tick)
    );

    rca_mem_model mem_u (
        .clk        (clk),
        .reset      (reset),
        .pm_addr    (pm_addr),
        .pm_rdata   (pm_rdata),
        .dm_req     (dm_req),
        .dm_rdata   (dm_rdata),
        .cycle_tick (cycle_tick)
    );

    always #12.5 clk = ~clk;

    // The command pulse stands one clk, so it is caught at the edge after launch
    always @(posedge clk) begin
        if (reset) begin
            aux_n <= 0;
        end else if (aux_w.valid) begin
            aux_last <= aux_w;
            aux_n    <= aux_n + 1;
        end
    end

    // =========================================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Fresh program space and a four-clock reset before each scenario
    task automatic start();
        for (int i = 0; i < (1 << `PC_W); i++) mem_u.rom[i] = `NOP_WORD;
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask

    // Bounded wait for the next tick; g counts falling edges waited
    task automatic wait_tick(output int g);
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (cycle_tick !== 1'b1 && g < 40);
        if (cycle_tick !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] tick wait expected 1 seen %b", cycle_tick);
            close_out();
        end
    endtask

    task automatic run_ticks(input int n);
        int g;
        repeat (n) wait_tick(g);
        repeat (3) @(negedge clk);
    endtask

    // =========================================================
    // Scenarios
    task automatic sc_cycle();
        int               g;
        logic [`PC_W-1:0] last;
        start();
        wait_tick(g);
        last = pm_addr;
        repeat (4) begin
            wait_tick(g);
            check("tick gap", 16'(g), 16'(`CLKS_PER_CYC));
            check("fetch addr", 16'(pm_addr), 16'(last + 9'h001));
            last = pm_addr;
        end
    endtask

    // Each case: W and file 0x10 loaded, op into file, status copied to 0x11
    task automatic sc_arith();
        logic [11:0] op  [8] = '{12'h1F0, 12'h1F0, 12'h1F0, 12'h0B0,
                                 12'h0B0, 12'h0B0, 12'h1B0, 12'h270};
        logic [7:0]  fv  [8] = '{8'h0F, 8'hFF, 8'h7F, 8'h01, 8'h10, 8'h33, 8'h5A, 8'h0F};
        logic [7:0]  wv  [8] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h01, 8'h33, 8'h5A, 8'h00};
        logic [7:0]  rv  [8] = '{8'h10, 8'h00, 8'h80, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'hF0};
        logic [2:0]  flg [8] = '{3'b010, 3'b111, 3'b010, 3'b000,
                                 3'b001, 3'b111, 3'b100, 3'b000};
        for (int k = 0; k < 8; k++) begin
            start();
            mem_u.rom[0] = {4'hC, fv[k]};
            mem_u.rom[1] = 12'h030;
            mem_u.rom[2] = {4'hC, wv[k]};
            mem_u.rom[3] = op[k];
            mem_u.rom[4] = 12'h203;
            mem_u.rom[5] = 12'h031;
            run_ticks(8);
            check("result addr", 16'(mem_u.log_addr[1]), 16'h0010);
            check("result", 16'(mem_u.log_data[1]), 16'(rv[k]));
            check("flags", 16'(mem_u.log_data[2][2:0]), 16'(flg[k]));
        end
    endtask

    // Jump over two words: the write after it must land in cycle 5
    task automatic sc_branch();
        start();
        mem_u.rom[0] = 12'hA03;
        mem_u.rom[1] = 12'hC55;
        mem_u.rom[2] = 12'h030;
        mem_u.rom[3] = 12'hC77;
        mem_u.rom[4] = 12'h031;
        run_ticks(7);
        check("write count", 16'(mem_u.log_addr.size()), 16'h0001);
        check("write addr", 16'(mem_u.log_addr[0]), 16'h0011);
        check("write data", 16'(mem_u.log_data[0]), 16'h0077);
        check("write cycle", 16'(mem_u.log_tick[0]), 16'h0005);
    endtask

    // Call, a system command, then return with a literal into the accumulator
    task automatic sc_call();
        start();
        mem_u.rom[0] = 12'h902;
        mem_u.rom[1] = 12'h031;
        mem_u.rom[2] = 12'hC44;
        mem_u.rom[3] = 12'h002;
        mem_u.rom[4] = 12'h866;
        run_ticks(9);
        check("ret write addr", 16'(mem_u.log_addr[0]), 16'h0011);
        check("ret write data", 16'(mem_u.log_data[0]), 16'h0066);
        check("ret write cycle", 16'(mem_u.log_tick[0]), 16'h0008);
        check("cmd count", 16'(aux_n), 16'h0001);
        check("cmd kind", 16'(aux_last.kind), 16'(aux_option));
        check("cmd port", 16'(aux_last.port), 16'h0002);
        check("cmd data", 16'(aux_last.data), 16'h0044);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        clk        = 1'b0;
        reset      = 1'b1;
        n_mismatch = 0;
        cmp_count  = 0;
        sc_cycle();
        sc_arith();
        sc_branch();
        sc_call();
        close_out();
    end
endmodule // testbench
